// ===== design/csa_pkg.sv
package csa_pkg;

    // Bus geometry
    localparam int CSA_DATA_W      = 32;
    localparam int CSA_ADDR_W      = 32;
    localparam int CSA_MAX_MASTERS = 4;

    // Transfer types
    localparam logic [1:0] CSA_TRANS_IDLE   = 2'h0;
    localparam logic [1:0] CSA_TRANS_BUSY   = 2'h1;
    localparam logic [1:0] CSA_TRANS_NONSEQ = 2'h2;
    localparam logic [1:0] CSA_TRANS_SEQ    = 2'h3;

    // Burst and response codes
    localparam logic [2:0] CSA_BURST_SINGLE = 3'h0;
    localparam logic       CSA_RESP_OKAY    = 1'b0;

    // Reset values
    localparam int          CSA_DEFAULT_MASTER = 0;
    localparam logic        CSA_SCHEME_RESET   = 1'b0;
    localparam logic [31:0] CSA_RDATA_IDLE     = 32'h0000_0000;

    typedef enum logic
    {
        CSA_FIXED_PRIORITY,
        CSA_ROUND_ROBIN
    } csa_scheme_type;

    typedef struct packed
    {
        logic [1:0]            trans;
        logic [CSA_ADDR_W-1:0] addr;
        logic                  write;
        logic [2:0]            size;
        logic [2:0]            burst;
        logic [CSA_DATA_W-1:0] wdata;
    } csa_mst_req_type;

    typedef struct packed
    {
        logic                  ready;
        logic                  resp;
        logic [CSA_DATA_W-1:0] rdata;
    } csa_mst_rsp_type;

    typedef struct packed
    {
        logic [1:0]            trans;
        logic [CSA_ADDR_W-1:0] addr;
        logic                  write;
        logic [2:0]            size;
        logic [2:0]            burst;
        logic [CSA_DATA_W-1:0] wdata;
        logic [1:0]            master;
        logic                  ready;
    } csa_slv_req_type;

    typedef struct packed
    {
        logic                  readyout;
        logic                  resp;
        logic [CSA_DATA_W-1:0] rdata;
    } csa_slv_rsp_type;

endpackage : csa_pkg

// ===== design/csa_crossbar.sv
// Contract
// RULE1 - Up to four masters reach different slaves concurrently; contention alone arbitrates.
// RULE2 - Thirty-two bit data path, same clock as the masters, no rate conversion.
// RULE3 - Access taken at once; a free port carries it the same cycle.
// RULE4 - A busy or foreign-parked port stalls the requester with wait states.
// RULE5 - Grant to a new port only after the previous other-port access completes.
// RULE6 - Owner keeps the port until it idles or targets elsewhere.
// RULE7 - Owner loses the port to a higher priority requester.
// RULE8 - Idle transfers from a master are completed by the switch itself.
// RULE9 - A port with no requester carries idle transfers.
// RULE10 - An idle port stays parked on its last master.
// RULE11 - One global scheme input: 0 fixed priority, 1 round robin.
// RULE12 - No rearbitration inside a burst until its final beat.
// RULE13 - Fixed mode: highest numbered master ranks highest and wins contention.
// RULE14 - Fixed mode: arbitration every edge, comparing against the owner unless parked.
// RULE15 - Fixed mode: higher requester granted next edge when owner not mid-transfer.
// RULE16 - Fixed mode: lower requester waits for owner idle or other-port cycle.
// RULE17 - Round robin ranks by distance after last master; handover at transfer boundary.
// RULE18 - Round robin owner continues until another requests; then next in line.
// RULE19 - No software registers, no initialization; scheme comes from an input.
// RULE20 - After reset every port parks on a default master and drives idle.
`timescale 1ns/1ps
`default_nettype none

module csa_crossbar
#(
    parameter int NUM_MASTERS    = 4,
    parameter int NUM_SLAVES     = 4,
    parameter int DEFAULT_MASTER = csa_pkg::CSA_DEFAULT_MASTER
)
(
    // Clock and reset
    input  wire logic                                     sys_clk,
    input  wire logic                                     nrst,
    // Global arbitration setting
    input  wire logic                                     arbitration_scheme_select,
    // Master ports
    input  wire csa_pkg::csa_mst_req_type [NUM_MASTERS-1:0] mst_req,
    output var  csa_pkg::csa_mst_rsp_type [NUM_MASTERS-1:0] mst_rsp,
    // Slave ports
    output var  csa_pkg::csa_slv_req_type [NUM_SLAVES-1:0]  slv_req,
    input  wire csa_pkg::csa_slv_rsp_type [NUM_SLAVES-1:0]  slv_rsp
);
    import csa_pkg::*;

    localparam int MW = $clog2(NUM_MASTERS);
    localparam int SW = $clog2(NUM_SLAVES);

    generate
        if (NUM_MASTERS < 2 || NUM_MASTERS > CSA_MAX_MASTERS || NUM_SLAVES < 2
            || (NUM_SLAVES & (NUM_SLAVES - 1)) != 0 || DEFAULT_MASTER >= NUM_MASTERS)
        begin : g_bad_params
            $error("csa_crossbar: unsupported master or slave count");
        end
    endgenerate

    // Scheme input is a strap from outside; two stages before use
    logic           scheme_meta;
    logic           scheme_sync;
    csa_scheme_type scheme;

    // Per-port arbitration state
    logic [MW-1:0]          owner      [NUM_SLAVES];
    logic [MW-1:0]          next_owner [NUM_SLAVES];
    logic [MW-1:0]          last_xfer  [NUM_SLAVES];
    logic                   sdp_valid  [NUM_SLAVES];
    logic [MW-1:0]          sdp_mst    [NUM_SLAVES];
    logic [NUM_MASTERS-1:0] elig       [NUM_SLAVES];
    logic                   slv_ready  [NUM_SLAVES];
    logic                   present    [NUM_SLAVES];
    logic                   acc        [NUM_SLAVES];
    logic                   own_busy   [NUM_SLAVES];
    logic                   locked     [NUM_SLAVES];
    logic                   switch_ok  [NUM_SLAVES];

    // Per-master data-phase state
    logic          mdp_active [NUM_MASTERS];
    logic [SW-1:0] mdp_slv    [NUM_MASTERS];
    logic [SW-1:0] tgt        [NUM_MASTERS];
    logic          dp_done    [NUM_MASTERS];
    logic          mst_acc    [NUM_MASTERS];
    logic                  held       [NUM_MASTERS];
    logic                  held_resp  [NUM_MASTERS];
    logic [CSA_DATA_W-1:0] held_rdata [NUM_MASTERS];

    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            scheme_meta <= CSA_SCHEME_RESET;
            scheme_sync <= CSA_SCHEME_RESET;
        end
        else
        begin
            scheme_meta <= arbitration_scheme_select; // RULE19
            scheme_sync <= scheme_meta;
        end
    end

    assign scheme = csa_scheme_type'(scheme_sync); // RULE11

    // Qualification of requests
    always_comb
    begin
        for (int m = 0; m < NUM_MASTERS; m++)
        begin
            tgt[m]     = mst_req[m].addr[CSA_ADDR_W-1 -: SW];
            dp_done[m] = !mdp_active[m] || held[m] || slv_rsp[mdp_slv[m]].readyout;
        end
        for (int s = 0; s < NUM_SLAVES; s++)
        begin
            slv_ready[s] = !sdp_valid[s] || slv_rsp[s].readyout;
            for (int m = 0; m < NUM_MASTERS; m++)
            begin
                // A pending access elsewhere hides the request from this port
                elig[s][m] = mst_req[m].trans != CSA_TRANS_IDLE && tgt[m] == SW'(s)
                             && (!mdp_active[m] || mdp_slv[m] == SW'(s) || dp_done[m]); // RULE5
            end
            own_busy[s] = elig[s][owner[s]]; // RULE6
            present[s]  = own_busy[s] && dp_done[owner[s]]; // RULE3
            acc[s]      = present[s] && slv_ready[s];
            locked[s]   = (own_busy[s] && (mst_req[owner[s]].trans == CSA_TRANS_SEQ
                                           || mst_req[owner[s]].trans == CSA_TRANS_BUSY))
                          || (acc[s] && mst_req[owner[s]].trans == CSA_TRANS_NONSEQ
                              && mst_req[owner[s]].burst != CSA_BURST_SINGLE); // RULE12
            // An address held by a waited slave must not change hands
            switch_ok[s] = !locked[s] && (slv_ready[s] || !present[s]);
        end
        for (int m = 0; m < NUM_MASTERS; m++)
        begin
            mst_acc[m] = 1'b0;
            for (int s = 0; s < NUM_SLAVES; s++)
            begin
                if (acc[s] && owner[s] == MW'(m))
                begin
                    mst_acc[m] = 1'b1; // RULE1
                end
            end
        end
    end

    // Arbitration, rerun at every edge
    always_comb
    begin
        int  idx;
        logic found;
        idx   = 0;
        found = 1'b0;
        for (int s = 0; s < NUM_SLAVES; s++)
        begin
            next_owner[s] = owner[s]; // RULE10
            found         = 1'b0;
            if (switch_ok[s])
            begin
                if (scheme == CSA_FIXED_PRIORITY)
                begin
                    // Ascending scan leaves the highest eligible master
                    for (int m = 0; m < NUM_MASTERS; m++)
                    begin
                        if (elig[s][m] && (m > int'(owner[s]) || !own_busy[s])) // RULE14
                        begin
                            next_owner[s] = MW'(m); // RULE13 RULE7 RULE15 RULE16
                        end
                    end
                end
                else
                begin
                    // The last master comes last in the circular scan
                    for (int k = 1; k <= NUM_MASTERS; k++)
                    begin
                        // A beat taken this cycle already counts as the last transfer
                        idx = (int'(acc[s] ? owner[s] : last_xfer[s]) + k) % NUM_MASTERS;
                        if (!found && elig[s][idx])
                        begin
                            next_owner[s] = MW'(idx); // RULE17 RULE18
                            found         = 1'b1;
                        end
                    end
                end
            end
        end
    end

    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            for (int s = 0; s < NUM_SLAVES; s++)
            begin
                owner[s]     <= MW'(DEFAULT_MASTER); // RULE20
                last_xfer[s] <= MW'(DEFAULT_MASTER);
            end
        end
        else
        begin
            for (int s = 0; s < NUM_SLAVES; s++)
            begin
                owner[s] <= next_owner[s];
                if (acc[s])
                begin
                    last_xfer[s] <= owner[s]; // RULE17
                end
            end
        end
    end

    // Data-phase tracking per slave port
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            for (int s = 0; s < NUM_SLAVES; s++)
            begin
                sdp_valid[s] <= 1'b0;
                sdp_mst[s]   <= MW'(DEFAULT_MASTER);
            end
        end
        else
        begin
            for (int s = 0; s < NUM_SLAVES; s++)
            begin
                if (slv_ready[s])
                begin
                    sdp_valid[s] <= present[s];
                    sdp_mst[s]   <= owner[s];
                end
            end
        end
    end

    // Data-phase tracking per master port
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            for (int m = 0; m < NUM_MASTERS; m++)
            begin
                mdp_active[m] <= 1'b0;
                mdp_slv[m]    <= '0;
                held[m]       <= 1'b0;
                held_resp[m]  <= CSA_RESP_OKAY;
                held_rdata[m] <= CSA_RDATA_IDLE;
            end
        end
        else
        begin
            for (int m = 0; m < NUM_MASTERS; m++)
            begin
                if (mst_rsp[m].ready)
                begin
                    // Idle cycles never open a data phase on a slave
                    mdp_active[m] <= mst_acc[m]; // RULE8
                    mdp_slv[m]    <= tgt[m];
                    held[m]       <= 1'b0;
                end
                else if (mdp_active[m] && !held[m] && slv_rsp[mdp_slv[m]].readyout)
                begin
                    // Slave ended the phase while the next address waits for a grant
                    held[m]       <= 1'b1; // RULE4
                    held_resp[m]  <= slv_rsp[mdp_slv[m]].resp;
                    held_rdata[m] <= slv_rsp[mdp_slv[m]].rdata;
                end
            end
        end
    end

    // Slave side: combinational so a free port costs no extra cycle
    always_comb
    begin
        for (int s = 0; s < NUM_SLAVES; s++)
        begin
            slv_req[s].trans  = present[s] ? mst_req[owner[s]].trans : CSA_TRANS_IDLE; // RULE9
            slv_req[s].addr   = mst_req[owner[s]].addr;
            slv_req[s].write  = mst_req[owner[s]].write;
            slv_req[s].size   = mst_req[owner[s]].size;
            slv_req[s].burst  = mst_req[owner[s]].burst;
            slv_req[s].wdata  = mst_req[sdp_mst[s]].wdata; // RULE2
            slv_req[s].master = 2'(owner[s]);
            slv_req[s].ready  = slv_ready[s];
        end
    end

    // Master side
    always_comb
    begin
        for (int m = 0; m < NUM_MASTERS; m++)
        begin
            mst_rsp[m].ready = dp_done[m]
                               && (mst_req[m].trans == CSA_TRANS_IDLE || mst_acc[m]); // RULE4
            mst_rsp[m].resp  = !mdp_active[m] ? CSA_RESP_OKAY
                               : held[m] ? held_resp[m] : slv_rsp[mdp_slv[m]].resp;
            mst_rsp[m].rdata = !mdp_active[m] ? CSA_RDATA_IDLE
                               : held[m] ? held_rdata[m] : slv_rsp[mdp_slv[m]].rdata;
        end
    end

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!nrst);

    generate
        for (genvar gs = 0; gs < NUM_SLAVES; gs++)
        begin : g_slv_chk
            a_free_port_zero: assert property ( // RULE3
                acc[gs] |-> mst_rsp[owner[gs]].ready && slv_req[gs].trans != CSA_TRANS_IDLE)
                else $error("free port did not pass access in the same cycle");
            a_idle_port_drive: assert property ( // RULE9
                elig[gs] == '0 |-> slv_req[gs].trans == CSA_TRANS_IDLE)
                else $error("port without requester not idle");
            a_park_last_owner: assert property ( // RULE10
                elig[gs] == '0 |=> owner[gs] == $past(owner[gs]))
                else $error("idle port moved off its last master");
            a_burst_lock_hold: assert property ( // RULE12
                locked[gs] |=> owner[gs] == $past(owner[gs]))
                else $error("port rearbitrated inside a burst");
            a_fixed_top_wins: assert property ( // RULE13
                scheme == CSA_FIXED_PRIORITY && switch_ok[gs] && elig[gs][NUM_MASTERS-1]
                |=> owner[gs] == MW'(NUM_MASTERS-1))
                else $error("highest master lost fixed contention");
            a_fixed_low_wait: assert property ( // RULE16
                scheme == CSA_FIXED_PRIORITY && own_busy[gs]
                && (elig[gs] >> owner[gs]) == NUM_MASTERS'(1)
                |=> owner[gs] == $past(owner[gs]))
                else $error("lower master took a busy port");
            a_rr_hand_over: assert property ( // RULE18
                scheme == CSA_ROUND_ROBIN && switch_ok[gs]
                && (elig[gs] & ~(NUM_MASTERS'(1) << owner[gs])) != '0
                |=> owner[gs] != $past(owner[gs]))
                else $error("round robin kept owner despite other requester");
            a_slave_wdata_src: assert property ( // RULE2
                acc[gs] ##1 slv_rsp[gs].readyout |-> slv_req[gs].wdata
                == mst_req[$past(owner[gs])].wdata)
                else $error("write data routed from wrong master");
            c_contention: cover property (
                $countones(elig[gs]) > 1 ##1 acc[gs]);
            c_rr_switch: cover property (
                scheme == CSA_ROUND_ROBIN && acc[gs] ##1 owner[gs] != $past(owner[gs]));
            c_burst_locked: cover property (
                locked[gs] [*3]);
        end
        for (genvar gm = 0; gm < NUM_MASTERS; gm++)
        begin : g_mst_chk
            a_one_port_each: assert property ( // RULE1
                mst_acc[gm] |-> mst_rsp[gm].ready ##1 mdp_active[gm]
                && mdp_slv[gm] == $past(tgt[gm]))
                else $error("accepted access not tracked to its port");
            a_idle_self_done: assert property ( // RULE8
                mst_req[gm].trans == CSA_TRANS_IDLE && dp_done[gm]
                |-> mst_rsp[gm].ready ##1 !mdp_active[gm])
                else $error("idle transfer not completed by the switch");
            a_stall_no_grant: assert property ( // RULE4
                mst_req[gm].trans != CSA_TRANS_IDLE && !mst_acc[gm] |-> !mst_rsp[gm].ready)
                else $error("ungranted master saw no wait state");
            a_prev_first: assert property ( // RULE5
                mdp_active[gm] && !dp_done[gm] && tgt[gm] != mdp_slv[gm]
                |-> !mst_acc[gm])
                else $error("new port served before previous access completed");
            c_zero_wait: cover property (
                mst_acc[gm] ##1 mst_acc[gm] && dp_done[gm]);
        end
    endgenerate

endmodule : csa_crossbar

`default_nettype wire

// ===== sim/csa_slave_model.sv
`timescale 1ns/1ps
`default_nettype none

module csa_slave_model
(
    // Clock and reset
    input  wire logic                     sys_clk,
    input  wire logic                     nrst,
    // Wait states added to every data phase
    input  wire logic [1:0]               wait_n,
    // Slave bus
    input  wire csa_pkg::csa_slv_req_type slv_req,
    output var  csa_pkg::csa_slv_rsp_type slv_rsp
);
    import csa_pkg::*;

    logic        dph;
    logic [1:0]  cnt;
    logic [31:0] addr;
    logic [31:0] junk;
    logic        done;

    assign done = dph && (cnt == wait_n);
    // Outside a finished data phase the lines carry noise, so stale data never matches
    assign slv_rsp.readyout = !dph || done;
    assign slv_rsp.resp     = done ? CSA_RESP_OKAY : junk[0];
    assign slv_rsp.rdata    = done ? (addr ^ 32'ha5a5_a5a5) : junk;

    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            dph  <= 1'b0;
            cnt  <= 2'h0;
            addr <= 32'h0000_0000;
            junk <= 32'h1357_9bdf;
        end
        else
        begin
            junk <= junk * 32'h0001_0dcd + 32'h3c6e_f372;
            if (slv_req.ready)
            begin
                dph  <= slv_req.trans != CSA_TRANS_IDLE;
                cnt  <= 2'h0;
                addr <= slv_req.addr;
            end
            else
            begin
                cnt <= cnt + 2'h1;
            end
        end
    end

endmodule : csa_slave_model

`default_nettype wire

// ===== sim/tb_crossbar_switch_arbiter.sv
`timescale 1ns/1ps
`default_nettype none

module tb_crossbar_switch_arbiter;
    import csa_pkg::*;

    localparam int SAMP = 2;

    logic                  sys_clk;
    logic                  nrst;
    logic                  arbitration_scheme_select;
    csa_mst_req_type [3:0] mst_req;
    csa_mst_rsp_type [3:0] mst_rsp;
    csa_slv_req_type [3:0] slv_req;
    csa_slv_rsp_type [3:0] slv_rsp;
    logic [1:0]            wait_n [4];
    logic [31:0]           exp_q [4][$];
    logic [1:0]            ord_q [4][$];
    logic [3:0]            dph;
    logic                  req;
    int                    wv [4];
    int                    w;
    int                    bad_count;
    int                    checked;

    csa_crossbar i_dut (
        .sys_clk                   (sys_clk),
        .nrst                      (nrst),
        .arbitration_scheme_select (arbitration_scheme_select),
        .mst_req                   (mst_req),
        .mst_rsp                   (mst_rsp),
        .slv_req                   (slv_req),
        .slv_rsp                   (slv_rsp)
    );

    for (genvar s = 0; s < 4; s++)
    begin : g_slv
        csa_slave_model i_slv (
            .sys_clk (sys_clk),
            .nrst    (nrst),
            .wait_n  (wait_n[s]),
            .slv_req (slv_req[s]),
            .slv_rsp (slv_rsp[s])
        );
    end

    always #2.5 sys_clk = ~sys_clk;

    task automatic check(input logic ok, input string msg);
        checked++;
        if (ok !== 1'b1)
        begin
            bad_count++;
            $display("ERROR at %0t: %s", $time, msg);
        end
    endtask : check

    task automatic complete_run;
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : complete_run

    // One hex digit per granted beat, oldest first
    function automatic logic [23:0] order_code(input int s);
        order_code = 24'h0;
        for (int i = 0; i < ord_q[s].size(); i++)
            order_code = {order_code[19:0], 2'b00, ord_q[s][i]};
    endfunction : order_code

    // Entered at a falling edge; the expected read data is noted once the address is taken
    task automatic rd(input int m, input int s, input int n, input logic bst, input logic hold,
                      output int wt);
        logic [31:0] a;
        a = {2'(s), 30'($urandom) & 30'h0fff_fff0};
        wt = 0;
        for (int b = 0; b < n; b++)
        begin
            mst_req[m].trans = (bst && b > 0) ? CSA_TRANS_SEQ : CSA_TRANS_NONSEQ;
            mst_req[m].addr  = a + 32'(4 * b);
            mst_req[m].burst = bst ? 3'h1 : CSA_BURST_SINGLE;
            #SAMP;
            while (mst_rsp[m].ready !== 1'b1 && wt < 64)
            begin
                @(negedge sys_clk);
                #SAMP;
                wt++;
            end
            exp_q[m].push_back((a + 32'(4 * b)) ^ 32'ha5a5_a5a5);
            @(negedge sys_clk);
        end
        if (!hold)
            mst_req[m].trans = CSA_TRANS_IDLE;
    endtask : rd

    // Sampled just before each rising edge, once the combinational paths have settled
    always @(negedge sys_clk)
    begin
        #SAMP;
        if (nrst)
        begin
            for (int m = 0; m < 4; m++)
            begin
                if (dph[m] && mst_rsp[m].ready === 1'b1)
                begin
                    check(exp_q[m].size() > 0 && mst_rsp[m].rdata === exp_q[m][0] &&
                          mst_rsp[m].resp === CSA_RESP_OKAY, "read data mismatch");
                    if (exp_q[m].size() > 0)
                        void'(exp_q[m].pop_front());
                    dph[m] = 1'b0;
                end
                if (!dph[m] && mst_req[m].trans == CSA_TRANS_IDLE)
                    check(mst_rsp[m].ready === 1'b1, "idle transfer not completed");
                if (mst_rsp[m].ready === 1'b1 && mst_req[m].trans != CSA_TRANS_IDLE)
                    dph[m] = 1'b1;
            end
            for (int s = 0; s < 4; s++)
            begin
                req = 1'b0;
                for (int m = 0; m < 4; m++)
                    req |= mst_req[m].trans != CSA_TRANS_IDLE && mst_req[m].addr[31:30] == 2'(s);
                if (!req)
                    check(slv_req[s].trans === CSA_TRANS_IDLE, "unrequested port not idle");
                if (slv_req[s].trans != CSA_TRANS_IDLE && slv_req[s].ready === 1'b1)
                    ord_q[s].push_back(slv_req[s].master);
            end
        end
    end

    initial
    begin
        #(5 * 5000);
        bad_count++;
        complete_run();
    end

    initial
    begin
        sys_clk = 1'b0;
        nrst = 1'b0;
        arbitration_scheme_select = CSA_SCHEME_RESET;
        bad_count = 0;
        checked = 0;
        dph = 4'h0;
        void'($urandom(79));
        for (int m = 0; m < 4; m++)
        begin
            mst_req[m] = '0;
            mst_req[m].size = 3'h2;
            mst_req[m].wdata = $urandom;
            wait_n[m] = 2'h0;
        end
        repeat (10) @(negedge sys_clk);
        nrst = 1'b1;
        #SAMP;
        for (int s = 0; s < 4; s++)
            check(slv_req[s].master === 2'h0 && slv_req[s].trans === CSA_TRANS_IDLE,
                  "port not parked idle on default master");
        @(negedge sys_clk);
        rd(0, 0, 1, 1'b0, 1'b0, w);
        check(w === 0, "parked port added wait states");
        rd(1, 1, 1, 1'b0, 1'b0, w);
        check(w === 1, "foreign parked port not stalled once");
        repeat (3) @(negedge sys_clk);
        rd(1, 1, 1, 1'b0, 1'b0, w);
        check(w === 0, "idle port lost its parking");
        repeat (2)
        begin
            for (int m = 0; m < 4; m++)
                fork
                    automatic int j = m;
                    rd(j, j, 1, 1'b0, 1'b0, wv[j]);
                join_none
            wait fork;
            @(negedge sys_clk);
        end
        for (int m = 0; m < 4; m++)
            check(wv[m] === 0, "concurrent access stalled");
        ord_q[2].delete();
        fork
            rd(1, 2, 1, 1'b0, 1'b0, wv[1]);
            rd(3, 2, 3, 1'b0, 1'b0, wv[3]);
        join
        check(order_code(2) === 24'h003331, "fixed priority order wrong");
        ord_q[3].delete();
        fork
            rd(0, 3, 4, 1'b0, 1'b0, wv[0]);
            begin
                repeat (2) @(negedge sys_clk);
                rd(2, 3, 1, 1'b0, 1'b0, wv[2]);
            end
        join
        check(ord_q[3].size() == 5 && ord_q[3][4] === 2'd0, "owner kept port from higher");
        wait_n[1] = 2'h1;
        ord_q[1].delete();
        fork
            rd(0, 1, 4, 1'b1, 1'b0, wv[0]);
            begin
                repeat (3) @(negedge sys_clk);
                rd(3, 1, 1, 1'b0, 1'b0, wv[3]);
            end
        join
        check(order_code(1) === 24'h000003 && ord_q[1].size() == 5, "burst was broken");
        wait_n[0] = 2'h3;
        rd(3, 0, 1, 1'b0, 1'b1, w);
        rd(3, 2, 1, 1'b0, 1'b0, w);
        check(w >= 3, "new port granted before old access ended");
        arbitration_scheme_select = 1'b1;
        repeat (4) @(negedge sys_clk);
        ord_q[3].delete();
        rd(2, 3, 1, 1'b0, 1'b0, w);
        for (int m = 0; m < 4; m++)
            if (m != 2)
                fork
                    automatic int j = m;
                    rd(j, 3, 1, 1'b0, 1'b0, wv[j]);
                join_none
        wait fork;
        check(order_code(3) === 24'h002301, "round robin order wrong");
        repeat (10) @(negedge sys_clk);
        for (int m = 0; m < 4; m++)
            check(exp_q[m].size() == 0, "read never answered");
        complete_run();
    end

endmodule : tb_crossbar_switch_arbiter

`default_nettype wire
